//--- src/lcd_mcu_io_ports_and_divider.v
// port, lcd drive and divider logic of a 4-bit lcd controller
// Behaviour
// - key read copies scan inputs into accumulator
// - rising edge on edge input sets flag
// - edge test reports flag then clears it
// - level input held one instruction, testable
// - idle data pins drive output latch
// - latch load copies accumulator to latch
// - ram read/write move nibble over pins
// - ram read releases data pin drivers
// - accumulator transfer drives complementary outputs
// - sound array gives tone, extra segments
// - 34 shift register bits go out
// - outputs are segments or key strobes
// - ram transfer puts address on segments
// - two three-level lcd commons, half duty
// - level pin high/low test skips
// - 15-stage divider, last stage 1 Hz
// - divider read into accumulator by nibble
// - auto clear held one second after start
`timescale 1ns/1ps
`include "io_port_consts.vh"
module lcd_mcu_io_ports_and_divider #(
   parameter XTAL_TICK_CYC = `XTAL_TICK_CYC,
   parameter ACL_TICKS = `ACL_TICKS
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [3:0] scan_inputs,
   input wire edge_test_in,
   input wire level_test_in,
   input wire level_pin_in,
   input wire [3:0] bidir_data_pins_in,
   output reg [3:0] bidir_data_pins_out,
   output reg [3:0] bidir_data_pins_oe,
   output reg [3:0] acc_output_pins,
   output reg [33:0] segment_outputs,
   output reg [1:0] extra_segment_outputs,
   output reg sound_out,
   output reg [1:0] lcd_common_outputs,
   output reg [1:0] lcd_common_mid,
   output reg key_strobe_mode,
   output reg auto_clear
);
   reg [3:0] acc_reg;
   reg [3:0] data_out_latch;
   reg edge_flag_reg;
   reg level_hold_reg;
   reg skip_reg;
   reg [3:0] ctrl_reg;
   reg [33:0] seg_reg;
   reg [7:0] ram_addr_reg;
   reg [1:0] xfer_reg;
   reg [14:0] div_reg;
   reg [15:0] tick_cnt_reg;
   reg [15:0] acl_cnt_reg;
   reg acl_reg;
   reg [1:0] lcd_phase_reg;
   reg [3:0] op_pending;
   reg [3:0] op_arg;
   wire edge_lvl;
   wire edge_rise;
   wire level_sync;
   wire apb_wr;
   wire xtal_tick;
   wire div_tick;
   reg [31:0] rd_mux;
   localparam XFER_IDLE = 2'b00;
   localparam XFER_READ = 2'b01;
   localparam XFER_WRITE = 2'b10;

   // edge input is asynchronous to pclk; catch it cleanly
   sync_edge u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .din(edge_test_in),
      .level(edge_lvl),
      .rise(edge_rise)
   );
   sync_edge u_level (
      .pclk(pclk),
      .presetn(presetn),
      .din(level_test_in),
      .level(level_sync),
      .rise()
   );

   assign apb_wr = psel & penable & pwrite & pready;
   assign xtal_tick = (tick_cnt_reg == XTAL_TICK_CYC - 1);
   assign div_tick = xtal_tick & ~acl_reg;

   // crystal tick derived from pclk
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= 16'h0000;
      end else if (xtal_tick) begin
         tick_cnt_reg <= 16'h0000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
   end

   // auto clear holds the block for one second of crystal time
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acl_cnt_reg <= 16'h0000;
         acl_reg <= 1'b1;
      end else if (acl_reg && xtal_tick) begin
         if (acl_cnt_reg == ACL_TICKS - 1) begin
            acl_reg <= 1'b0;
         end else begin
            acl_cnt_reg <= acl_cnt_reg + 16'h0001;
         end
      end
   end

   // single cycle answer: pready is high in the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & ~penable;
      end
   end

   always @* begin
      rd_mux = 32'h00000000;
      case (paddr)
         `REG_CTRL: rd_mux = {28'h0000000, ctrl_reg};
         `REG_ACC: rd_mux = {28'h0000000, acc_reg};
         `REG_OP: rd_mux = {28'h0000000, op_arg};
         `REG_STATUS: rd_mux = {24'h000000, acl_reg, xfer_reg,
            edge_flag_reg, level_hold_reg, skip_reg, level_pin_in,
            edge_lvl};
         `REG_SEG_LO: rd_mux = seg_reg[31:0];
         `REG_SEG_HI: rd_mux = {30'h00000000, seg_reg[33:32]};
         `REG_LCD: rd_mux = {17'h00000, div_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= rd_mux;
            pslverr <= (paddr > `REG_LCD) || (paddr[1:0] != 2'b00);
         end
      end
   end

   // op register write launches one instruction; executed next cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_pending <= 4'h0;
         op_arg <= 4'h0;
      end else if (apb_wr && paddr == `REG_OP && !acl_reg) begin
         op_pending <= pwdata[3:0];
         op_arg <= pwdata[7:4];
      end else begin
         op_pending <= 4'h0;
      end
   end

   // main datapath
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= 4'h0;
         data_out_latch <= 4'h0;
         edge_flag_reg <= 1'b0;
         level_hold_reg <= 1'b0;
         skip_reg <= 1'b0;
         ctrl_reg <= 4'h0;
         seg_reg <= 34'h000000000;
         ram_addr_reg <= 8'h00;
         xfer_reg <= XFER_IDLE;
         acc_output_pins <= 4'h0;
      end else if (acl_reg) begin
         acc_reg <= 4'h0;
         edge_flag_reg <= 1'b0;
         xfer_reg <= XFER_IDLE;
      end else begin
         // level is captured every instruction slot and held
         level_hold_reg <= level_sync;
         xfer_reg <= XFER_IDLE;
         // pins were released a cycle ago, so the ram drives them now
         if (xfer_reg == XFER_READ) begin
            acc_reg <= bidir_data_pins_in;
         end
         if (apb_wr && paddr == `REG_CTRL) begin
            ctrl_reg <= pwdata[3:0];
         end
         if (apb_wr && paddr == `REG_ACC) begin
            acc_reg <= pwdata[3:0];
         end
         if (apb_wr && paddr == `REG_SEG_LO) begin
            seg_reg[31:0] <= pwdata;
         end
         if (apb_wr && paddr == `REG_SEG_HI) begin
            seg_reg[33:32] <= pwdata[1:0];
         end
         if (apb_wr && paddr == `REG_LCD) begin
            ram_addr_reg <= pwdata[7:0];
         end
         case (op_pending)
            `OP_KEY_READ: acc_reg <= scan_inputs;
            `OP_LEVEL_TEST: skip_reg <= level_hold_reg;
            `OP_LOAD_LATCH: data_out_latch <= acc_reg;
            `OP_ACC_OUT: acc_output_pins <= acc_reg;
            `OP_RAM_READ: begin
               xfer_reg <= XFER_READ;
            end
            `OP_RAM_WRITE: xfer_reg <= XFER_WRITE;
            `OP_DIV_READ: begin
               case (op_arg[1:0])
                  2'b00: acc_reg <= div_reg[3:0];
                  2'b01: acc_reg <= div_reg[7:4];
                  2'b10: acc_reg <= div_reg[11:8];
                  default: acc_reg <= {1'b0, div_reg[14:12]};
               endcase
            end
            `OP_BA_TEST: skip_reg <= level_pin_in;
            `OP_SEG_SHIFT: seg_reg <= {acc_reg, seg_reg[33:4]};
            default: ;
         endcase
         // test reports the flag and clears it; a new edge wins
         if (op_pending == `OP_EDGE_TEST) begin
            skip_reg <= edge_flag_reg;
            edge_flag_reg <= edge_rise;
         end else if (edge_rise) begin
            edge_flag_reg <= 1'b1;
         end
      end
   end

   // 15-stage divider, advanced by crystal ticks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 15'h0000;
      end else if (op_pending == `OP_DIV_RESET || acl_reg) begin
         div_reg <= 15'h0000;
      end else if (div_tick) begin
         div_reg <= div_reg + 15'h0001;
      end
   end

   // lcd frame phase from divider: 4 phases per frame
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcd_phase_reg <= 2'h0;
      end else begin
         lcd_phase_reg <= div_reg[7:6];
      end
   end

   // data pin drivers, all registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bidir_data_pins_out <= 4'h0;
         bidir_data_pins_oe <= 4'h0;
      end else begin
         if (op_pending == `OP_RAM_READ) begin
            bidir_data_pins_oe <= 4'h0;
            bidir_data_pins_out <= data_out_latch;
         end else if (op_pending == `OP_RAM_WRITE) begin
            bidir_data_pins_oe <= 4'hF;
            bidir_data_pins_out <= acc_reg;
         end else begin
            bidir_data_pins_oe <= 4'hF;
            bidir_data_pins_out <= data_out_latch;
         end
      end
   end

   // address on segment lines while a transfer runs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         segment_outputs <= 34'h000000000;
      end else if (op_pending == `OP_RAM_READ ||
            op_pending == `OP_RAM_WRITE) begin
         segment_outputs <= {26'h0000000, ram_addr_reg};
      end else begin
         segment_outputs <= seg_reg;
      end
   end

   // tone from divider, extra segments from accumulator output pins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sound_out <= 1'b0;
         extra_segment_outputs <= 2'b00;
      end else if (ctrl_reg[`CTRL_SOUND_BIT]) begin
         sound_out <= div_reg[2];
         extra_segment_outputs <= acc_output_pins[1:0];
      end else begin
         sound_out <= 1'b0;
         extra_segment_outputs <= 2'b00;
      end
   end

   // half bias, half duty: mid level in alternate phases
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcd_common_outputs <= 2'b00;
         lcd_common_mid <= 2'b00;
      end else begin
         lcd_common_mid <= lcd_phase_reg[0] ? 2'b11 : 2'b00;
         case (lcd_phase_reg)
            2'b00: lcd_common_outputs <= 2'b01;
            2'b10: lcd_common_outputs <= 2'b10;
            default: lcd_common_outputs <= 2'b00;
         endcase
      end
   end

   // scan strobe or segment use of the shift register lines
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_strobe_mode <= 1'b0;
      end else begin
         key_strobe_mode <= ctrl_reg[`CTRL_KEYSCAN_BIT];
      end
   end

   // pin flag lags the internal auto clear by one cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_clear <= 1'b1;
      end else begin
         auto_clear <= acl_reg;
      end
   end
endmodule

//--- common/io_port_consts.vh
// constants for the lcd microcontroller port and divider block
`ifndef IO_PORT_CONSTS_VH
`define IO_PORT_CONSTS_VH
`define APB_ADDR_W 8
// register byte offsets
`define REG_CTRL 8'h00
`define REG_ACC 8'h04
`define REG_OP 8'h08
`define REG_STATUS 8'h0C
`define REG_SEG_LO 8'h10
`define REG_SEG_HI 8'h14
`define REG_LCD 8'h18
// operation codes written to the op register
`define OP_KEY_READ 4'h1
`define OP_EDGE_TEST 4'h2
`define OP_LEVEL_TEST 4'h3
`define OP_LOAD_LATCH 4'h4
`define OP_ACC_OUT 4'h5
`define OP_RAM_READ 4'h6
`define OP_RAM_WRITE 4'h7
`define OP_DIV_RESET 4'h8
`define OP_DIV_READ 4'h9
`define OP_BA_TEST 4'hA
`define OP_SEG_SHIFT 4'hB
// control field positions
`define CTRL_KEYSCAN_BIT 0
`define CTRL_SOUND_BIT 1
// geometry
`define SEG_BITS 34
`define DIV_STAGES 15
// timing: crystal tick period and auto-clear time
`define XTAL_HZ 32768
`define CLK_HZ 20000000
`define ACL_TIME_MS 1000
`define XTAL_TICK_CYC (`CLK_HZ / `XTAL_HZ)
`define ACL_TICKS ((`ACL_TIME_MS * `XTAL_HZ) / 1000)
`endif

//--- src/sync_edge.v
// two flop synchroniser with rising edge detect
`timescale 1ns/1ps
module sync_edge (
   input wire pclk,
   input wire presetn,
   input wire din,
   output reg level,
   output wire rise
);
   reg meta_reg;
   reg prev_reg;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b0;
         level <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= din;
         level <= meta_reg;
         prev_reg <= level;
      end
   end
   assign rise = level & ~prev_reg;
endmodule

//--- tb/io_port_props.sv
// assertion checker for the port and divider block
`timescale 1ns/1ps
module io_port_props #(
   parameter XTAL_TICK_CYC = 4,
   parameter ACL_TICKS = 8
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire [3:0] bidir_data_pins_out,
   input wire [3:0] bidir_data_pins_oe,
   input wire [3:0] acc_output_pins,
   input wire key_strobe_mode,
   input wire [1:0] lcd_common_outputs,
   input wire [1:0] lcd_common_mid,
   input wire auto_clear
);
   localparam integer ACL_CYC = XTAL_TICK_CYC * ACL_TICKS;
   wire wr = psel && penable && pready && pwrite && !auto_clear;
   wire wr_op = wr && paddr == 8'h08;
   wire [3:0] code = pwdata[3:0];
   wire pin_go = wr_op && (code == 4'h4 || code == 4'h6 || code == 4'h7);
   wire acc_go = wr_op && code == 4'h5;
   reg [3:0] since_pin;
   reg [3:0] since_acc;
   reg [31:0] up_cnt;
   // saturating age counters: a pin change long after the op that drives it is a fault
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_pin <= 4'hF;
         since_acc <= 4'hF;
         up_cnt <= 32'h0;
      end else begin
         up_cnt <= up_cnt + 32'h1;
         since_pin <= pin_go ? 4'h0 : since_pin + {3'h0, since_pin != 4'hF};
         since_acc <= acc_go ? 4'h0 : since_acc + {3'h0, since_acc != 4'hF};
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_ram_read;
      wr_op && code == 4'h6;
   endsequence
   property p_mode;
      (wr && paddr == 8'h00) |-> ##2 key_strobe_mode == $past(pwdata[0], 2);
   endproperty
   AST_SETUP_READY: assert property (psel && !penable |=> pready)
      else $error("no ready in first access cycle");
   AST_BAD_ADDR: assert property (psel && penable && pready
      && paddr > 8'h18 |-> pslverr) else $error("bad address accepted");
   AST_PIN_IDLE: assert property (bidir_data_pins_oe != 4'hF
      |-> bidir_data_pins_oe == 4'h0) else $error("partial pin drive");
   AST_READ_RELEASE: assert property (s_ram_read
      |-> ##[1:4] bidir_data_pins_oe == 4'h0) else $error("pins not released");
   AST_LATCH_CAUSE: assert property ($changed(bidir_data_pins_out)
      |-> since_pin < 4'h6) else $error("latch changed without op");
   AST_ACC_CAUSE: assert property ($changed(acc_output_pins)
      |-> since_acc < 4'h6) else $error("outputs changed without op");
   AST_CLEAR_HOLD: assert property (up_cnt + 2 < ACL_CYC
      |-> auto_clear) else $error("auto clear ended early");
   AST_CLEAR_END: assert property (up_cnt > ACL_CYC + 4
      |-> !auto_clear) else $error("auto clear ended late");
   AST_STROBE_MODE: assert property (p_mode)
      else $error("display mode not taken");
   AST_COMMON_MID: assert property (lcd_common_mid != 2'b00
      |-> lcd_common_outputs == 2'b00) else $error("common driven at mid");
   AST_COMMON_SEL: assert property (up_cnt != 32'h0
      && lcd_common_mid == 2'b00 |-> lcd_common_outputs == 2'b01
      || lcd_common_outputs == 2'b10) else $error("no common selected");
endmodule
bind lcd_mcu_io_ports_and_divider io_port_props #(
   .XTAL_TICK_CYC(XTAL_TICK_CYC), .ACL_TICKS(ACL_TICKS)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .bidir_data_pins_out(bidir_data_pins_out),
   .bidir_data_pins_oe(bidir_data_pins_oe),
   .acc_output_pins(acc_output_pins), .key_strobe_mode(key_strobe_mode),
   .lcd_common_outputs(lcd_common_outputs),
   .lcd_common_mid(lcd_common_mid), .auto_clear(auto_clear));

//--- tb/ext_ram_model.sv
// external nibble ram seen through the bidirectional data pins
`timescale 1ns/1ps
module ext_ram_model (
   input wire [33:0] segment_outputs,
   input wire [3:0] pins_out,
   input wire [3:0] pins_oe,
   output wire [3:0] pins_in
);
   reg [3:0] mem [0:15];
   integer k;
   initial begin
      for (k = 0; k < 16; k = k + 1)
         mem[k] = 4'hF - k[3:0];
   end
   // ram answers at the address on the segment lines
   wire [3:0] ram_q = mem[segment_outputs[3:0]];
   assign pins_in = (pins_out & pins_oe) | (ram_q & ~pins_oe);
endmodule

//--- tb/testbench.sv
// self-checking bench for the port and divider block
`timescale 1ns/1ps
module testbench;
   reg pclk, presetn, psel, penable, pwrite, er;
   reg edge_test_in, level_test_in, level_pin_in;
   reg [7:0] paddr;
   reg [31:0] pwdata, rd;
   reg [3:0] scan_inputs;
   wire [31:0] prdata;
   wire pready, pslverr, key_mode, aclr;
   wire [3:0] pin_in, pin_out, pin_oe, acc_out;
   wire [33:0] seg;
   wire [1:0] extra_seg;
   integer n_mismatch, checks, i;
   lcd_mcu_io_ports_and_divider #(.XTAL_TICK_CYC(4), .ACL_TICKS(8)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scan_inputs(scan_inputs),
      .edge_test_in(edge_test_in), .level_test_in(level_test_in),
      .level_pin_in(level_pin_in), .bidir_data_pins_in(pin_in),
      .bidir_data_pins_out(pin_out), .bidir_data_pins_oe(pin_oe),
      .acc_output_pins(acc_out), .segment_outputs(seg),
      .extra_segment_outputs(extra_seg), .sound_out(), .lcd_common_outputs(),
      .lcd_common_mid(), .key_strobe_mode(key_mode), .auto_clear(aclr));
   ext_ram_model u_ram (.segment_outputs(seg), .pins_out(pin_out),
      .pins_oe(pin_oe), .pins_in(pin_in));
   task summarize;
      begin
         if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // one idle edge at the end keeps back-to-back calls single-driven
   task apb(input w, input [7:0] a, input [31:0] d);
      integer k;
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k = k + 1;
         end
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (k == 20) begin
            n_mismatch = n_mismatch + 1;
            summarize;
         end
         @(posedge pclk);
      end
   endtask
   task op(input [7:0] c);
      begin
         apb(1'b1, 8'h08, {24'h0, c});
         repeat (3) @(posedge pclk);
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      scan_inputs = 4'h0;
      edge_test_in = 1'b0;
      level_test_in = 1'b0;
      level_pin_in = 1'b0;
      n_mismatch = 0;
      checks = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, 8'h04, 32'h5);
      apb(1'b0, 8'h04, 32'h0);
      cmp(rd, 32'h0);
      cmp({28'h0, pin_oe}, 32'hF);
      i = 0;
      while (aclr !== 1'b0 && i < 100) begin
         @(posedge pclk);
         i = i + 1;
      end
      if (i == 100) begin
         n_mismatch = n_mismatch + 1;
         summarize;
      end
      scan_inputs <= 4'hA;
      op(8'h01);
      apb(1'b0, 8'h04, 32'h0);
      cmp(rd, 32'hA);
      apb(1'b1, 8'h04, 32'h5);
      op(8'h04);
      cmp({28'h0, pin_out}, 32'h5);
      op(8'h05);
      cmp({28'h0, acc_out}, 32'h5);
      edge_test_in <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, 8'h0C, 32'h0);
      cmp(rd & 32'h10, 32'h10);
      op(8'h02);
      apb(1'b0, 8'h0C, 32'h0);
      cmp(rd & 32'h14, 32'h4);
      op(8'h02);
      apb(1'b0, 8'h0C, 32'h0);
      cmp(rd & 32'h14, 32'h0);
      edge_test_in <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         level_test_in <= i[0];
         level_pin_in <= i[0];
         repeat (4) @(posedge pclk);
         op(i[1] ? 8'h0A : 8'h03);
         apb(1'b0, 8'h0C, 32'h0);
         cmp(rd & 32'h4, {29'h0, i[0], 2'h0});
      end
      apb(1'b1, 8'h18, 32'h3);
      op(8'h06);
      apb(1'b0, 8'h04, 32'h0);
      cmp(rd, 32'hC);
      apb(1'b1, 8'h04, 32'h6);
      apb(1'b1, 8'h08, 32'h7);
      @(posedge pclk);
      cmp({28'h0, pin_out}, 32'h6);
      cmp(seg[31:0], 32'h3);
      repeat (3) @(posedge pclk);
      cmp({28'h0, pin_out}, 32'h5);
      op(8'h08);
      op(8'h39);
      apb(1'b0, 8'h04, 32'h0);
      cmp(rd, 32'h0);
      apb(1'b1, 8'h00, 32'h3);
      @(posedge pclk);
      cmp({31'h0, key_mode}, 32'h1);
      cmp({30'h0, extra_seg}, 32'h1);
      apb(1'b1, 8'h14, 32'hFFFFFFFF);
      apb(1'b0, 8'h14, 32'h0);
      cmp(rd, 32'h3);
      cmp({30'h0, seg[33:32]}, 32'h3);
      apb(1'b1, 8'h04, 32'h9);
      op(8'h0B);
      apb(1'b0, 8'h10, 32'h0);
      cmp(rd, 32'h70000000);
      apb(1'b0, 8'h14, 32'h0);
      cmp(rd, 32'h2);
      repeat (600) @(posedge pclk);
      apb(1'b0, 8'h1C, 32'h0);
      cmp({31'h0, er}, 32'h1);
      summarize;
   end
endmodule
